/* pkg/current_detect_pkg.sv */
// Constants for the output current detector: register map, resets, limits and timing
package current_detect_pkg;

   // Register byte addresses
   localparam logic [7:0] ADDR_OC_LEVEL   = 8'h00;
   localparam logic [7:0] ADDR_OC_DELAY   = 8'h04;
   localparam logic [7:0] ADDR_ZC_LEVEL   = 8'h08;
   localparam logic [7:0] ADDR_ZC_TIME    = 8'h0C;
   localparam logic [7:0] ADDR_OC_RETAIN  = 8'h10;
   localparam logic [7:0] ADDR_OC_ACTION  = 8'h14;
   localparam logic [7:0] ADDR_STATUS     = 8'h18;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h20;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h24;
   localparam logic [7:0] ADDR_TERM_BASE  = 8'h28;
   localparam int         TERM_COUNT      = 7;

   // Field positions in status and interrupt registers
   localparam int STAT_OC_BIT   = 0;
   localparam int STAT_ZC_BIT   = 1;
   localparam int STAT_TRIP_BIT = 2;
   localparam int IRQ_WIDTH     = 3;

   // Levels are whole percent of rated current, times are 10 ms units
   localparam logic [7:0]  OC_LEVEL_RESET  = 8'h0096;   // 150 %
   localparam logic [7:0]  LEVEL_MAX       = 8'h00DC;   // 220 %
   localparam logic [9:0]  OC_DELAY_RESET  = 10'h0000;  // 0 s
   localparam logic [9:0]  TIME_10S_MAX    = 10'h03E8;  // 10 s
   localparam logic [7:0]  ZC_LEVEL_RESET  = 8'h0005;   // 5 %
   localparam logic [6:0]  ZC_TIME_RESET   = 7'h32;     // 0.5 s
   localparam logic [6:0]  ZC_TIME_MAX     = 7'h64;     // 1 s
   localparam logic [13:0] OC_RETAIN_RESET = 14'h000A;  // 0.1 s
   localparam logic [13:0] RETAIN_FOREVER  = 14'h270F;  // 9999
   localparam logic [6:0]  ZC_MIN_ON_TICKS = 7'h0A;     // 0.1 s
   localparam logic        OC_ACTION_RESET = 1'b0;

   // Terminal function codes
   localparam logic [7:0] FN_OC_POS = 8'h0C;  // 12
   localparam logic [7:0] FN_OC_NEG = 8'h70;  // 112
   localparam logic [7:0] FN_ZC_POS = 8'h0D;  // 13
   localparam logic [7:0] FN_ZC_NEG = 8'h71;  // 113
   localparam logic [7:0] FN_RESET  = 8'h00;

   // Timebase: one tick every 10 ms at a 20 ns clock
   localparam int CLK_PERIOD_NS = 20;
   localparam int TICK_TIME_NS  = 10_000_000;
   localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
   localparam int TICK_W        = 19;

endpackage : current_detect_pkg

/* logic/output_current_detector.sv */
// Output current detector: overcurrent and zero-current signals with timing, trip and terminal routing
//
// What this block does
// - Overcurrent signal after current above level past delay
// - Overcurrent level percent of rated, 0-220, default 150
// - Overcurrent delay 0-10 s, default zero
// - Overcurrent signal held for retention time
// - Retention 9999 holds signal until next start
// - Action 0 keeps running while signal on
// - Action 1 trips with fault at signal turn-on
// - After trip, hold retention or until reset
// - Action change while on takes effect later
// - Overcurrent to terminal with code 12/112
// - Zero-current signal after current below level past time
// - Zero-current time 0-1 s from falling below
// - Zero-current signal held at least 0.1 s
// - Zero-current level 0 disables detection
// - Zero-current to terminal with code 13/113
// - Both signals respond within about 0.1 s
// - Detection stays active during motor tuning
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps

module output_current_detector
   import current_detect_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES
) (
   input  wire logic                  core_clk,
   input  wire logic                  srst,
   input  wire logic [7:0]            reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_write,
   input  wire logic                  reg_read,
   output logic      [31:0]           reg_rdata,
   input  wire logic [8:0]            output_current,
   input  wire logic                  drive_running,
   input  wire logic                  tuning_active,
   input  wire logic                  start_cmd,
   input  wire logic                  fault_reset,
   output logic                       overcurrent_detect_out,
   output logic                       zero_current_detect_out,
   output logic                       overcurrent_detect_fault,
   output logic                       trip_request,
   output logic      [TERM_COUNT-1:0] terminal_out,
   output logic                       irq
);

   typedef struct packed {
      logic [7:0]                 oc_level;
      logic [9:0]                 oc_delay;
      logic [7:0]                 zc_level;
      logic [6:0]                 zc_time;
      logic [13:0]                oc_retain;
      logic                       oc_action;
      logic [TERM_COUNT-1:0][7:0] term_fn;
      logic [TICK_W-1:0]          tick_cnt;
      logic [9:0]                 oc_timer;
      logic [13:0]                oc_hold;
      logic                       oc_on;
      logic                       tripped;
      logic                       trip_pulse;
      logic [6:0]                 zc_timer;
      logic [6:0]                 zc_hold;
      logic                       zc_on;
      logic [IRQ_WIDTH-1:0]       irq_status;
      logic [IRQ_WIDTH-1:0]       irq_enable;
      logic [TERM_COUNT-1:0]      term_out;
      logic [31:0]                rdata;
   } state_t;

   state_t                  st;
   state_t                  next_st;
   logic                    tick;
   logic                    operating;
   logic                    above;
   logic                    below;
   logic [TERM_COUNT-1:0]   term_level;

   // Level a terminal shows for a function code; unknown codes stay off
   function automatic logic term_decode(input logic [7:0] fn, input logic oc, input logic zc);
      logic r;
      r = 1'b0;
      if (fn == FN_OC_POS) begin
         r = oc;
      end else if (fn == FN_OC_NEG) begin
         r = ~oc;
      end else if (fn == FN_ZC_POS) begin
         r = zc;
      end else if (fn == FN_ZC_NEG) begin
         r = ~zc;
      end
      return r;
   endfunction : term_decode

   // Clamp a written value to a ceiling, so out-of-range writes saturate
   function automatic logic [13:0] clamp(input logic [31:0] v, input logic [13:0] lim);
      logic [13:0] r;
      r = (v > {18'h0_0000, lim}) ? lim : v[13:0];
      return r;
   endfunction : clamp

   // One terminal mapper per output; uses registered state, so terminals lag one cycle
   genvar gi;
   generate
      for (gi = 0; gi < TERM_COUNT; gi++) begin : g_term
         assign term_level[gi] = term_decode(st.term_fn[gi], st.oc_on, st.zc_on);
      end
   endgenerate

   // Comparisons are evaluated on the 10 ms tick, well inside the 0.1 s response
   assign tick      = (st.tick_cnt == TICK_W'(TICK_LEN - 1));
   assign operating = drive_running | tuning_active;
   assign above     = operating && (output_current > {1'b0, st.oc_level});
   assign below     = operating && (st.zc_level != 8'h00)
                      && (output_current < {1'b0, st.zc_level});

   // Next-state logic for registers, timers and detection flags
   always_comb begin
      logic [IRQ_WIDTH-1:0] events;
      logic [IRQ_WIDTH-1:0] clr;
      logic                 oc_fire;
      logic                 zc_fire;
      events     = '0;
      clr        = '0;
      // Fire flags default low so no path leaves them unset
      oc_fire    = 1'b0;
      zc_fire    = 1'b0;
      next_st    = st;
      next_st.trip_pulse = 1'b0;
      next_st.term_out   = term_level;
      next_st.tick_cnt   = tick ? '0 : st.tick_cnt + 1'b1;

      // Register writes; limits keep settings inside their documented ranges
      if (reg_write) begin
         unique case (reg_addr)
            ADDR_OC_LEVEL:   next_st.oc_level  = 8'(clamp(reg_wdata, {6'h00, LEVEL_MAX}));
            ADDR_OC_DELAY:   next_st.oc_delay  = 10'(clamp(reg_wdata, {4'h0, TIME_10S_MAX}));
            ADDR_ZC_LEVEL:   next_st.zc_level  = 8'(clamp(reg_wdata, {6'h00, LEVEL_MAX}));
            ADDR_ZC_TIME:    next_st.zc_time   = 7'(clamp(reg_wdata, {7'h00, ZC_TIME_MAX}));
            ADDR_OC_RETAIN:  next_st.oc_retain = (reg_wdata == {18'h0_0000, RETAIN_FOREVER}) ?
                                                 RETAIN_FOREVER :
                                                 clamp(reg_wdata, {4'h0, TIME_10S_MAX});
            ADDR_OC_ACTION:  next_st.oc_action = reg_wdata[0];
            ADDR_IRQ_CLEAR:  clr               = reg_wdata[IRQ_WIDTH-1:0];
            ADDR_IRQ_ENABLE: next_st.irq_enable = reg_wdata[IRQ_WIDTH-1:0];
            default: begin
               for (int i = 0; i < TERM_COUNT; i++) begin
                  if (reg_addr == ADDR_TERM_BASE + 8'(4 * i)) begin
                     next_st.term_fn[i] = reg_wdata[7:0];
                  end
               end
            end
         endcase
      end

      // Overcurrent delay timer counts ticks above level, restarts when it drops
      if (tick) begin
         if (!above) begin
            next_st.oc_timer = '0;
         end else if (st.oc_timer != TIME_10S_MAX) begin
            next_st.oc_timer = st.oc_timer + 1'b1;
         end
      end
      oc_fire = tick && above && !st.oc_on && (st.oc_timer >= st.oc_delay);

      // Action is sampled only at turn-on, so changing it while on does nothing yet
      if (oc_fire) begin
         next_st.oc_on   = 1'b1;
         next_st.oc_hold = '0;
         events[STAT_OC_BIT] = 1'b1;
         if (st.oc_action) begin
            next_st.tripped    = 1'b1;
            next_st.trip_pulse = 1'b1;
            events[STAT_TRIP_BIT] = 1'b1;
         end
      end else if (st.oc_on) begin
         if (tick && st.oc_hold != TIME_10S_MAX) begin
            next_st.oc_hold = st.oc_hold + 1'b1;
         end
         if (st.oc_retain == RETAIN_FOREVER) begin
            if (st.tripped ? fault_reset : start_cmd) begin
               next_st.oc_on = 1'b0;
            end
         end else if (tick && st.oc_hold >= st.oc_retain && !above) begin
            next_st.oc_on = 1'b0;
         end
      end
      if (fault_reset) begin
         next_st.tripped = next_st.trip_pulse;
      end

      // Zero-current timer mirrors the overcurrent one
      if (tick) begin
         if (!below) begin
            next_st.zc_timer = '0;
         end else if (st.zc_timer != ZC_TIME_MAX) begin
            next_st.zc_timer = st.zc_timer + 1'b1;
         end
      end
      zc_fire = tick && below && !st.zc_on && (st.zc_timer >= st.zc_time);
      if (zc_fire) begin
         next_st.zc_on   = 1'b1;
         next_st.zc_hold = '0;
         events[STAT_ZC_BIT] = 1'b1;
      end else if (st.zc_on) begin
         if (tick && st.zc_hold != ZC_MIN_ON_TICKS) begin
            next_st.zc_hold = st.zc_hold + 1'b1;
         end
         if (tick && st.zc_hold >= ZC_MIN_ON_TICKS && !below) begin
            next_st.zc_on = 1'b0;
         end
      end
      // Disabling beats the minimum on time: a zero level must silence the signal now
      if (next_st.zc_level == 8'h00) begin
         next_st.zc_on = 1'b0;
      end

      // Sticky interrupt bits: a new event wins over a clear in the same cycle
      next_st.irq_status = (st.irq_status & ~clr) | events;

      // Registered read port; unmapped addresses read zero
      next_st.rdata = '0;
      if (reg_read) begin
         unique case (reg_addr)
            ADDR_OC_LEVEL:   next_st.rdata = {24'h00_0000, st.oc_level};
            ADDR_OC_DELAY:   next_st.rdata = {22'h00_0000, st.oc_delay};
            ADDR_ZC_LEVEL:   next_st.rdata = {24'h00_0000, st.zc_level};
            ADDR_ZC_TIME:    next_st.rdata = {25'h000_0000, st.zc_time};
            ADDR_OC_RETAIN:  next_st.rdata = {18'h0_0000, st.oc_retain};
            ADDR_OC_ACTION:  next_st.rdata = {31'h0000_0000, st.oc_action};
            ADDR_STATUS:     next_st.rdata = {29'h0000_0000, st.tripped, st.zc_on, st.oc_on};
            ADDR_IRQ_STATUS: next_st.rdata = {29'h0000_0000, st.irq_status};
            ADDR_IRQ_ENABLE: next_st.rdata = {29'h0000_0000, st.irq_enable};
            default: begin
               for (int i = 0; i < TERM_COUNT; i++) begin
                  if (reg_addr == ADDR_TERM_BASE + 8'(4 * i)) begin
                     next_st.rdata = {24'h00_0000, st.term_fn[i]};
                  end
               end
            end
         endcase
      end
   end

   // State register; reset restores defaults and drops any held trip
   always_ff @(posedge core_clk) begin
      if (srst) begin
         st           <= '0;
         st.oc_level  <= OC_LEVEL_RESET;
         st.oc_delay  <= OC_DELAY_RESET;
         st.zc_level  <= ZC_LEVEL_RESET;
         st.zc_time   <= ZC_TIME_RESET;
         st.oc_retain <= OC_RETAIN_RESET;
         st.oc_action <= OC_ACTION_RESET;
         st.term_fn   <= {TERM_COUNT{FN_RESET}};
      end else begin
         st <= next_st;
      end
   end

   // Outputs
   assign reg_rdata                = st.rdata;
   assign overcurrent_detect_out   = st.oc_on;
   assign zero_current_detect_out  = st.zc_on;
   assign overcurrent_detect_fault = st.tripped;
   assign trip_request             = st.trip_pulse;
   assign terminal_out             = st.term_out;
   assign irq                      = |(st.irq_status & st.irq_enable);

   // Checks on the detection behaviour
   sequence s_oc_rise;
      $rose(st.oc_on);
   endsequence

   // Turn-on with the trip action latched at that moment
   sequence s_trip_fire;
      s_oc_rise and $past(st.oc_action);
   endsequence

   // Zero-current turn-on, used by the threshold and time checks
   sequence s_zc_rise;
      $rose(st.zc_on);
   endsequence

   a_oc_needs_above: assert property (@(posedge core_clk) disable iff (srst)
      s_oc_rise |-> $past(above) && $past(tick))
      else $error("overcurrent signal rose without current above level");

   a_oc_trip_on: assert property (@(posedge core_clk) disable iff (srst)
      s_trip_fire |-> st.tripped && trip_request)
      else $error("trip missing at overcurrent turn-on");

   a_trip_only_rise: assert property (@(posedge core_clk) disable iff (srst)
      $rose(st.tripped) |-> $rose(st.oc_on))
      else $error("trip occurred while signal already on");

   a_oc_retain_hold: assert property (@(posedge core_clk) disable iff (srst)
      $fell(st.oc_on) && $past(st.oc_retain) != RETAIN_FOREVER |-> $past(st.oc_hold) >= $past(st.oc_retain))
      else $error("overcurrent signal dropped before retention time");

   a_oc_forever: assert property (@(posedge core_clk) disable iff (srst)
      st.oc_on && st.oc_retain == RETAIN_FOREVER && !start_cmd && !fault_reset |=> st.oc_on)
      else $error("held overcurrent signal dropped without start or reset");

   a_zc_min_on: assert property (@(posedge core_clk) disable iff (srst)
      $fell(st.zc_on) && st.zc_level != 8'h00 |-> $past(st.zc_hold) >= ZC_MIN_ON_TICKS)
      else $error("zero-current signal shorter than minimum");

   a_zc_disabled: assert property (@(posedge core_clk) disable iff (srst)
      st.zc_level == 8'h00 |-> !st.zc_on)
      else $error("zero-current signal on while disabled");

   a_timer_restart: assert property (@(posedge core_clk) disable iff (srst)
      tick && !above |=> st.oc_timer == 10'h000)
      else $error("overcurrent delay timer did not restart");

   a_term_oc_route: assert property (@(posedge core_clk) disable iff (srst)
      st.term_fn[1] == FN_OC_NEG |=> terminal_out[1] == !$past(st.oc_on))
      else $error("negative-logic overcurrent routing wrong");

   a_term_zc_route: assert property (@(posedge core_clk) disable iff (srst)
      st.term_fn[2] == FN_ZC_POS |=> terminal_out[2] == $past(st.zc_on))
      else $error("zero-current routing wrong");

   // Trip pulses, thresholds, delays, idle quiet, holds and the strobes that end a hold
   a_trip_single: assert property (@(posedge core_clk) disable iff (srst)
      s_trip_fire |=> !trip_request)
      else $error("trip request longer than one cycle");

   a_oc_no_trip: assert property (@(posedge core_clk) disable iff (srst)
      s_oc_rise and !$past(st.oc_action) |-> !trip_request)
      else $error("trip raised with continue action");

   a_fault_hold: assert property (@(posedge core_clk) disable iff (srst)
      st.tripped && !fault_reset |=> st.tripped)
      else $error("fault flag dropped without fault reset");

   a_oc_start_off: assert property (@(posedge core_clk) disable iff (srst)
      st.oc_on && !st.tripped && st.oc_retain == RETAIN_FOREVER && start_cmd |=> !st.oc_on)
      else $error("held overcurrent signal ignored start");

   a_trip_reset_off: assert property (@(posedge core_clk) disable iff (srst)
      st.oc_on && st.tripped && st.oc_retain == RETAIN_FOREVER && fault_reset |=> !st.oc_on && !st.tripped)
      else $error("held tripped signal ignored fault reset");

   a_oc_hold_above: assert property (@(posedge core_clk) disable iff (srst)
      st.oc_on && above && !start_cmd && !fault_reset |=> st.oc_on)
      else $error("overcurrent signal dropped while current above level");

   a_oc_delay_met: assert property (@(posedge core_clk) disable iff (srst)
      s_oc_rise |-> $past(st.oc_timer) >= $past(st.oc_delay))
      else $error("overcurrent signal rose before delay");

   a_zc_needs_below: assert property (@(posedge core_clk) disable iff (srst)
      s_zc_rise |-> $past(below) && $past(tick))
      else $error("zero-current signal rose without current below level");

   a_zc_time_met: assert property (@(posedge core_clk) disable iff (srst)
      s_zc_rise |-> $past(st.zc_timer) >= $past(st.zc_time))
      else $error("zero-current signal rose before its time");

   a_zc_hold_below: assert property (@(posedge core_clk) disable iff (srst)
      st.zc_on && below |=> st.zc_on || st.zc_level == 8'h00)
      else $error("zero-current signal dropped while current below level");

   a_oc_idle_quiet: assert property (@(posedge core_clk) disable iff (srst)
      !operating && !st.oc_on |=> !st.oc_on)
      else $error("overcurrent signal rose while drive idle");

   a_zc_idle_quiet: assert property (@(posedge core_clk) disable iff (srst)
      !operating && !st.zc_on |=> !st.zc_on)
      else $error("zero-current signal rose while drive idle");

endmodule : output_current_detector

/* tb/drive_feedback_model.sv */
// Behavioural model of the drive's current measurement and run state feeding the detector
`timescale 1ns/10ps

module drive_feedback_model (
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic [8:0] cmd_current,
   input  wire logic       cmd_run,
   output logic      [8:0] output_current,
   output logic            drive_running
);
   // One cycle of measurement lag, so the detector never sees a step in the cycle it was asked for
   always_ff @(posedge core_clk) begin
      if (srst) begin
         output_current <= 9'h000;
         drive_running  <= 1'b0;
      end else begin
         output_current <= cmd_current;
         drive_running  <= cmd_run;
      end
   end
endmodule : drive_feedback_model

/* tb/tb.sv */
// Self-checking testbench for the output current detector
`timescale 1ns/10ps

module tb;
   import current_detect_pkg::*;
   localparam int TL = 4;
   logic        core_clk      = 1'b0;
   logic        srst          = 1'b1;
   logic [7:0]  reg_addr      = 8'h00;
   logic [31:0] reg_wdata     = 32'h0000_0000;
   logic        reg_write     = 1'b0;
   logic        reg_read      = 1'b0;
   logic [8:0]  cmd_current   = 9'h000;
   logic        cmd_run       = 1'b0;
   logic        tuning_active = 1'b0;
   logic        start_cmd     = 1'b0;
   logic        fault_reset   = 1'b0;
   logic [31:0] reg_rdata;
   logic [8:0]  output_current;
   logic        drive_running, oc, zc, flt, trq, irq;
   logic [6:0]  term;
   logic [31:0] v;
   int          error_cnt       = 0;
   int          samples_checked = 0;
   int          n;
   logic [7:0]  ra [6] = '{ADDR_OC_LEVEL, ADDR_OC_DELAY, ADDR_ZC_LEVEL, ADDR_ZC_TIME, ADDR_OC_RETAIN, ADDR_OC_ACTION};
   logic [31:0] rv [6] = '{32'h0000_0096, 32'h0000_0000, 32'h0000_0005, 32'h0000_0032, 32'h0000_000A, 32'h0000_0000};

   // 50 MHz clock
   always #10 core_clk = ~core_clk;

   drive_feedback_model i_drive_feedback_model (.core_clk(core_clk), .srst(srst), .cmd_current(cmd_current),
      .cmd_run(cmd_run), .output_current(output_current), .drive_running(drive_running));

   // Short tick keeps every timed setting a few cycles long
   output_current_detector #(.TICK_LEN(TL)) i_output_current_detector (.core_clk(core_clk), .srst(srst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .output_current(output_current), .drive_running(drive_running),
      .tuning_active(tuning_active), .start_cmd(start_cmd), .fault_reset(fault_reset),
      .overcurrent_detect_out(oc), .zero_current_detect_out(zc), .overcurrent_detect_fault(flt),
      .trip_request(trq), .terminal_out(term), .irq(irq));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask : cyc

   // Bus cycles: strobe dropped one edge before the next request can raise it again
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1;
      v = reg_rdata;
   endtask : rd

   task automatic cur(input logic [8:0] x);
      @(posedge core_clk);
      cmd_current <= x;
   endtask : cur

   task automatic pulse(input bit is_reset);
      @(posedge core_clk);
      if (is_reset) fault_reset <= 1'b1;
      else start_cmd <= 1'b1;
      @(posedge core_clk);
      fault_reset <= 1'b0;
      start_cmd   <= 1'b0;
   endtask : pulse

   // Bounded wait for a detector output: 0 overcurrent, 1 zero current, 2 fault
   task automatic wt(input int which, input logic val, input int lim, output int cnt);
      logic s;
      cnt = 0;
      do begin
         @(posedge core_clk);
         #1;
         cnt++;
         s = (which == 0) ? oc : (which == 1) ? zc : flt;
      end while (s !== val && cnt < lim);
   endtask : wt

   task automatic wrap_up;
      $display("checks=%0d errors=%0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up

   // Watchdog, far beyond the few hundred cycles the sequence needs
   initial begin
      #(20 * 3000);
      error_cnt++;
      wrap_up();
   end

   initial begin
      void'($urandom(95));
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rd(ra[i]);
         chk(v, rv[i]);
      end
      rd(8'hFC);
      chk(v, 32'h0000_0000);
      wr(ADDR_TERM_BASE, 32'd12);
      wr(ADDR_TERM_BASE + 8'h04, 32'd112);
      wr(ADDR_TERM_BASE + 8'h08, 32'd13);
      wr(ADDR_TERM_BASE + 8'h0C, 32'd113);
      wr(ADDR_IRQ_ENABLE, 32'h0000_0007);
      wr(ADDR_OC_DELAY, 32'd3);
      wr(ADDR_OC_RETAIN, 32'd5);
      // Tuning alone counts as operating, the run flag stays low here
      @(posedge core_clk);
      tuning_active <= 1'b1;
      cur(9'(151 + $urandom_range(360)));
      wt(0, 1'b1, 40, n);
      chk(n >= TL * 3 + 2 && n <= TL * 3 + 5, 1);
      cur(9'd100);
      wt(0, 1'b0, 60, n);
      chk(n >= 4 * 4 && n <= 4 * 7, 1);
      // Zero current with a short time, then its minimum on time
      @(posedge core_clk);
      cmd_run <= 1'b1;
      wr(ADDR_ZC_TIME, 32'd2);
      cur(9'($urandom_range(4)));
      wt(1, 1'b1, 40, n);
      chk(n >= TL * 2 + 2 && n <= TL * 2 + 5, 1);
      cur(9'd100);
      wt(1, 1'b0, 80, n);
      chk(n >= 35 && n <= 48, 1);
      wr(ADDR_ZC_LEVEL, 32'd0);
      cur(9'd2);
      wt(1, 1'b1, 30, n);
      chk(zc, 1'b0);
      // Held until next start; action changed while on must not trip
      wr(ADDR_OC_RETAIN, 32'h0000_270F);
      wr(ADDR_OC_DELAY, 32'd0);
      cur(9'd300);
      wt(0, 1'b1, 20, n);
      chk(flt, 1'b0);
      cyc(2);
      chk(term, 7'h09);
      rd(ADDR_STATUS);
      chk(v, 32'h0000_0001);
      wr(ADDR_OC_ACTION, 32'd1);
      cur(9'd100);
      cyc(40);
      chk(oc, 1'b1);
      chk(flt, 1'b0);
      chk(irq, 1'b1);
      wr(ADDR_IRQ_ENABLE, 32'h0000_0000);
      cyc(1);
      chk(irq, 1'b0);
      pulse(1'b0);
      cyc(2);
      chk(oc, 1'b0);
      // Trip now that the new action is in force
      cur(9'd300);
      wt(0, 1'b1, 20, n);
      chk({flt, trq}, 2'b11);
      cyc(1);
      chk(trq, 1'b0);
      cur(9'd100);
      pulse(1'b0);
      cyc(2);
      chk(oc, 1'b1);
      pulse(1'b1);
      cyc(2);
      chk({oc, flt}, 2'b00);
      rd(ADDR_IRQ_STATUS);
      // The zero-current rise from earlier is still pending beside the overcurrent and trip bits
      chk(v, 32'h0000_0007);
      wr(ADDR_IRQ_ENABLE, 32'h0000_0007);
      wr(ADDR_IRQ_CLEAR, 32'h0000_0007);
      cyc(1);
      chk(irq, 1'b0);
      // A broken run of ticks above level restarts the delay
      wr(ADDR_OC_ACTION, 32'd0);
      wr(ADDR_OC_DELAY, 32'd3);
      cur(9'd300);
      cyc(6);
      cur(9'd100);
      cyc(8);
      cur(9'(200 + $urandom_range(300)));
      wt(0, 1'b1, 40, n);
      chk(n >= TL * 3 + 2 && n <= TL * 3 + 5, 1);
      wrap_up();
   end
endmodule : tb
